// ==== aecp_pkg.sv ====
// ---------------------------------------------------------------------------
// Shared constants of the event counter pair.
// ---------------------------------------------------------------------------
package aecp_pkg;

	// Register bus geometry.
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;

	// Register offsets on the plain register port.
	localparam logic [ADDR_W-1:0] OFS_CTRL_STATUS = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_COUNT_HIGH  = 3'h1;
	localparam logic [ADDR_W-1:0] OFS_COUNT_LOW   = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_CLOCK_SEL   = 3'h3;
	localparam logic [ADDR_W-1:0] OFS_EDGE_SEL    = 3'h4;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS  = 3'h5;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK    = 3'h6;

	// Control/status field positions.
	localparam int CS_HIGH_OVF    = 7;
	localparam int CS_LOW_OVF     = 6;
	localparam int CS_RESERVED    = 5;
	localparam int CS_SPLIT       = 4;
	localparam int CS_HIGH_CUE    = 3;
	localparam int CS_LOW_CUE     = 2;
	localparam int CS_HIGH_RUN    = 1;
	localparam int CS_LOW_RUN     = 0;
	localparam logic [5:0] CS_PLAIN_MASK = 6'h3F;

	// Clock select fields: [3:2] high half, [1:0] low half.
	localparam int CK_HIGH_LSB = 2;
	localparam int CK_LOW_LSB  = 0;

	// Edge select fields: [3:2] high pin, [1:0] low pin, bit 4 gate source.
	localparam int EG_HIGH_LSB  = 2;
	localparam int EG_LOW_LSB   = 0;
	localparam int EG_GATE_WAVE = 4;
	localparam logic [4:0] EG_MASK = 5'h1F;

	// Interrupt status and mask: bit 0 is the counter request.
	localparam int IRQ_COUNTER = 0;

	// Reset values.
	localparam logic [7:0] RST_BYTE = 8'h00;

	// Clock source codes.
	typedef enum logic [1:0]
	{
		AECP_SRC_PIN  = 2'b00,
		AECP_SRC_DIV2 = 2'b01,
		AECP_SRC_DIV4 = 2'b10,
		AECP_SRC_DIV8 = 2'b11
	} aecp_src_t;

	// Edge sense codes.
	typedef enum logic [1:0]
	{
		AECP_EDGE_FALL = 2'b00,
		AECP_EDGE_RISE = 2'b01,
		AECP_EDGE_BOTH = 2'b10,
		AECP_EDGE_NONE = 2'b11
	} aecp_edge_t;

endpackage

// ==== aecp_top.sv ====
`timescale 1ns/1ps
// Function
// - High overflow flag sets on high wrap.
// - Low overflow flag sets only in split mode.
// - Flag clears by zero write after read-one.
// - Writing one to flags does nothing.
// - Split bit: one 16-bit or two 8-bit.
// - High count-up enable gates high events.
// - Low count-up enable gates low events.
// - High reset-control zero holds high cleared.
// - Low reset-control zero holds low cleared.
// - High counter is read-only, resets zero.
// - High source: pin, divided clock, low carry.
// - High counter is upper byte when joined.
// - Low source: pin or divided clock.
// - Joined count wraps to zero, sets high flag.
// - Any overflow raises the interrupt request.
// - Counting only while selected gate is high.
// - Edge selector picks falling, rising or both.
module aecp_top
#(
	parameter int CNT_W = 8,
	parameter int PRE_W = 3
)
(
	input  wire logic                       mclk,
	input  wire logic                       resetn,
	input  wire logic                       clk_en,
	input  wire logic [aecp_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [aecp_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [aecp_pkg::DATA_W-1:0] reg_rdata,
	output logic                            irq,
	input  wire logic                       high_event_pin,
	input  wire logic                       low_event_pin,
	input  wire logic                       external_gate_pin,
	input  wire logic                       internal_gate_waveform
);

	// ---------------------------------------------------------------------
	// Elaboration checks.
	// ---------------------------------------------------------------------

	// The counters sit in byte-wide registers and the divider taps reach /8.
	if (CNT_W != aecp_pkg::DATA_W)
	begin : g_bad_cnt
		$error("Counter width must equal the register data width.");
	end
	if (PRE_W < 3)
	begin : g_bad_pre
		$error("Prescaler must be at least three bits wide.");
	end

	// ---------------------------------------------------------------------
	// Helper functions.
	// ---------------------------------------------------------------------

	// Turns a filtered level change into an event per the edge code.
	function automatic logic edge_hit(input logic [1:0] code,
		input logic prev, input logic cur);
		logic rise;
		logic fall;
		rise = ~prev & cur;
		fall = prev & ~cur;
		case (code)
			aecp_pkg::AECP_EDGE_FALL: edge_hit = fall;
			aecp_pkg::AECP_EDGE_RISE: edge_hit = rise;
			aecp_pkg::AECP_EDGE_BOTH: edge_hit = rise | fall;
			default:                  edge_hit = 1'b0;
		endcase
	endfunction

	// Picks the pin event or one of the divided system clock ticks.
	function automatic logic src_hit(input logic [1:0] code,
		input logic pin_ev, input logic [PRE_W-1:0] pre);
		case (code)
			aecp_pkg::AECP_SRC_PIN:  src_hit = pin_ev;
			aecp_pkg::AECP_SRC_DIV2: src_hit = &pre[0:0];
			aecp_pkg::AECP_SRC_DIV4: src_hit = &pre[1:0];
			default:                 src_hit = &pre[2:0];
		endcase
	endfunction

	// ---------------------------------------------------------------------
	// Pin synchronisers.
	// ---------------------------------------------------------------------

	localparam int NPIN = 3;                 // High, low, gate pins.
	logic [NPIN-1:0] pin_raw;               // Raw asynchronous pins.
	logic [NPIN-1:0] s1_q;                  // First stage, read by s2 only.
	logic [NPIN-1:0] s2_q;                  // Second stage.
	logic [NPIN-1:0] s3_q;                  // Third stage.
	logic [NPIN-1:0] lvl_q;                 // Accepted pin level.
	logic [NPIN-1:0] lvl_d;                 // Next accepted level.

	assign pin_raw = {external_gate_pin, low_event_pin, high_event_pin};

	// A change is accepted only when stages two and three agree, which
	// keeps a metastable settle from producing two events.
	genvar gi;
	for (gi = 0; gi < NPIN; gi++)
	begin : g_sync
		assign lvl_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : lvl_q[gi];
	end

	// Register the synchroniser chain; reset settles all to low.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			lvl_q <= '0;
		end
		else if (clk_en)
		begin
			s1_q  <= pin_raw;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	// ---------------------------------------------------------------------
	// Register state.
	// ---------------------------------------------------------------------

	logic [7:0]       cs_q, cs_d;             // Control/status byte.
	logic [1:0]       armed_q, armed_d;       // Flag read as one, per flag.
	logic [3:0]       cksel_q, cksel_d;       // Clock source selects.
	logic [4:0]       edge_q, edge_d;         // Edge selects and gate source.
	logic             irq_st_q, irq_st_d;     // Counter request flag.
	logic             irq_en_q, irq_en_d;     // Counter request enable.
	logic             irq_q, irq_d;           // Interrupt output register.
	logic [7:0]       rdata_q, rdata_d;       // Read data register.
	logic [CNT_W-1:0] high_q, high_d;         // High counter.
	logic [CNT_W-1:0] low_q, low_d;           // Low counter.
	logic [PRE_W-1:0] pre_q, pre_d;           // System clock prescaler.

	// ---------------------------------------------------------------------
	// Counting datapath.
	// ---------------------------------------------------------------------

	logic gate;         // Selected gate level.
	logic high_pin_ev;  // Qualified edge on the high pin.
	logic low_pin_ev;   // Qualified edge on the low pin.
	logic low_tick;     // Low counter advances this cycle.
	logic high_tick;    // High counter advances this cycle.
	logic low_wrap;     // Low counter wraps this cycle.
	logic high_wrap;    // High counter wraps this cycle.
	logic high_src;     // Source chosen for the high counter.

	always_comb
	begin
		// The gate source is the pin or the internal waveform.
		gate = edge_q[aecp_pkg::EG_GATE_WAVE] ? internal_gate_waveform
			: lvl_q[2];
		// Edge sense per pin; code 11 yields no events.
		high_pin_ev = edge_hit(edge_q[aecp_pkg::EG_HIGH_LSB +: 2],
			lvl_q[0], lvl_d[0]);
		low_pin_ev = edge_hit(edge_q[aecp_pkg::EG_LOW_LSB +: 2],
			lvl_q[1], lvl_d[1]);
		// Low half: pin or divided clock, gated, enabled, released.
		low_tick = gate & cs_q[aecp_pkg::CS_LOW_CUE]
			& cs_q[aecp_pkg::CS_LOW_RUN]
			& src_hit(cksel_q[aecp_pkg::CK_LOW_LSB +: 2], low_pin_ev,
			pre_q);
		low_wrap = low_tick & (&low_q);
		// In joined mode the low carry clocks the high half.
		high_src = cs_q[aecp_pkg::CS_SPLIT]
			? src_hit(cksel_q[aecp_pkg::CK_HIGH_LSB +: 2], high_pin_ev,
			pre_q)
			: low_wrap;
		high_tick = gate & cs_q[aecp_pkg::CS_HIGH_CUE]
			& cs_q[aecp_pkg::CS_HIGH_RUN] & high_src;
		high_wrap = high_tick & (&high_q);
		// Free-running prescaler for the divided clock taps.
		pre_d = pre_q + PRE_W'(1);
		// Each tick adds exactly one; a held reset forces zero.
		if (!cs_q[aecp_pkg::CS_LOW_RUN])
		begin
			low_d = '0;
		end
		else
		begin
			low_d = low_tick ? low_q + CNT_W'(1) : low_q;
		end
		if (!cs_q[aecp_pkg::CS_HIGH_RUN])
		begin
			high_d = '0;
		end
		else
		begin
			// The joined count wraps FFFF to 0000 and keeps going.
			high_d = high_tick ? high_q + CNT_W'(1) : high_q;
		end
	end

	// ---------------------------------------------------------------------
	// Register port and flags.
	// ---------------------------------------------------------------------

	logic wr_cs;  // Write to the control/status byte.
	logic rd_cs;  // Read of the control/status byte.
	logic set_h;  // High flag set event.
	logic set_l;  // Low flag set event.

	always_comb
	begin
		wr_cs = reg_wr && (reg_addr == aecp_pkg::OFS_CTRL_STATUS);
		rd_cs = reg_rd && (reg_addr == aecp_pkg::OFS_CTRL_STATUS);
		set_h = high_wrap;
		set_l = low_wrap & cs_q[aecp_pkg::CS_SPLIT];
		cs_d     = cs_q;
		armed_d  = armed_q;
		cksel_d  = cksel_q;
		edge_d   = edge_q;
		irq_st_d = irq_st_q;
		irq_en_d = irq_en_q;
		rdata_d  = aecp_pkg::RST_BYTE;
		// Plain control bits, reserved bit included, take the write.
		if (wr_cs)
		begin
			cs_d[5:0] = reg_wdata[5:0] & aecp_pkg::CS_PLAIN_MASK;
		end
		// A zero clears a flag only if it was read as one; ones are
		// ignored, and any write to the byte disarms.
		if (wr_cs && armed_q[1] && !reg_wdata[aecp_pkg::CS_HIGH_OVF])
		begin
			cs_d[aecp_pkg::CS_HIGH_OVF] = 1'b0;
		end
		if (wr_cs && armed_q[0] && !reg_wdata[aecp_pkg::CS_LOW_OVF])
		begin
			cs_d[aecp_pkg::CS_LOW_OVF] = 1'b0;
		end
		if (wr_cs)
		begin
			armed_d = 2'b00;
		end
		else if (rd_cs)
		begin
			armed_d = armed_q | {cs_q[aecp_pkg::CS_HIGH_OVF],
				cs_q[aecp_pkg::CS_LOW_OVF]};
		end
		// A new overflow wins over a clear in the same cycle.
		if (set_h)
		begin
			cs_d[aecp_pkg::CS_HIGH_OVF] = 1'b1;
		end
		if (set_l)
		begin
			cs_d[aecp_pkg::CS_LOW_OVF] = 1'b1;
		end
		// Decode the remaining writes; counters ignore writes.
		if (reg_wr && reg_addr == aecp_pkg::OFS_CLOCK_SEL)
		begin
			cksel_d = reg_wdata[3:0];
		end
		else if (reg_wr && reg_addr == aecp_pkg::OFS_EDGE_SEL)
		begin
			edge_d = reg_wdata[4:0] & aecp_pkg::EG_MASK;
		end
		else if (reg_wr && reg_addr == aecp_pkg::OFS_IRQ_STATUS)
		begin
			// Write one to clear.
			if (reg_wdata[aecp_pkg::IRQ_COUNTER])
			begin
				irq_st_d = 1'b0;
			end
		end
		else if (reg_wr && reg_addr == aecp_pkg::OFS_IRQ_MASK)
		begin
			irq_en_d = reg_wdata[aecp_pkg::IRQ_COUNTER];
		end
		// Any overflow requests an interrupt; set beats clear.
		if (set_h || set_l)
		begin
			irq_st_d = 1'b1;
		end
		irq_d = irq_st_d & irq_en_d;
		// Read data stands in the cycle after the strobe only.
		if (reg_rd && reg_addr == aecp_pkg::OFS_CTRL_STATUS)
		begin
			rdata_d = cs_q;
		end
		else if (reg_rd && reg_addr == aecp_pkg::OFS_COUNT_HIGH)
		begin
			rdata_d = high_q;
		end
		else if (reg_rd && reg_addr == aecp_pkg::OFS_COUNT_LOW)
		begin
			rdata_d = low_q;
		end
		else if (reg_rd && reg_addr == aecp_pkg::OFS_CLOCK_SEL)
		begin
			rdata_d = {4'h0, cksel_q};
		end
		else if (reg_rd && reg_addr == aecp_pkg::OFS_EDGE_SEL)
		begin
			rdata_d = {3'h0, edge_q};
		end
		else if (reg_rd && reg_addr == aecp_pkg::OFS_IRQ_STATUS)
		begin
			rdata_d = {7'h00, irq_st_q};
		end
		else if (reg_rd && reg_addr == aecp_pkg::OFS_IRQ_MASK)
		begin
			rdata_d = {7'h00, irq_en_q};
		end
	end

	// ---------------------------------------------------------------------
	// State registers.
	// ---------------------------------------------------------------------

	// All state freezes while the clock enable is low.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			cs_q     <= aecp_pkg::RST_BYTE;
			armed_q  <= 2'h0;
			cksel_q  <= 4'h0;
			edge_q   <= 5'h00;
			irq_st_q <= 1'b0;
			irq_en_q <= 1'b0;
			irq_q    <= 1'b0;
			rdata_q  <= aecp_pkg::RST_BYTE;
			high_q   <= '0;
			low_q    <= '0;
			pre_q    <= '0;
		end
		else if (clk_en)
		begin
			cs_q     <= cs_d;
			armed_q  <= armed_d;
			cksel_q  <= cksel_d;
			edge_q   <= edge_d;
			irq_st_q <= irq_st_d;
			irq_en_q <= irq_en_d;
			irq_q    <= irq_d;
			rdata_q  <= rdata_d;
			high_q   <= high_d;
			low_q    <= low_d;
			pre_q    <= pre_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign irq       = irq_q;

endmodule

// ==== aecp_top_properties.sv ====
`timescale 1ns/1ps
// --------------------
// Port checks of the event counter pair.
// --------------------
module aecp_top_properties
(
	input wire logic       mclk,
	input wire logic       resetn,
	input wire logic       clk_en,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       irq
);
	localparam logic [2:0] CS = aecp_pkg::OFS_CTRL_STATUS;
	localparam logic [2:0] HI = aecp_pkg::OFS_COUNT_HIGH;
	localparam logic [2:0] LO = aecp_pkg::OFS_COUNT_LOW;
	logic [7:0] ctrl_q, ctrl_d; // Last control byte written.
	logic       ien_q, ien_d;   // Last interrupt enable written.

	// Shadows follow accepted writes, so no internal probe is needed.
	always_comb
	begin
		ctrl_d = ctrl_q;
		ien_d  = ien_q;
		if (clk_en && reg_wr && reg_addr == CS)
			ctrl_d = reg_wdata;
		if (clk_en && reg_wr && reg_addr == aecp_pkg::OFS_IRQ_MASK)
			ien_d = reg_wdata[0];
	end

	// Shadows clear together with the block.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl_q <= 8'h00;
			ien_q  <= 1'b0;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			ien_q  <= ien_d;
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);

	// One accepted strobe of each kind.
	sequence wr_s(a);
		clk_en && reg_wr && reg_addr == a;
	endsequence
	sequence rd_s(a);
		clk_en && reg_rd && reg_addr == a;
	endsequence

	plain_bits_a: assert property (wr_s(CS) ##1 !reg_wr ##1 rd_s(CS)
		|=> reg_rdata[5:0] == $past(reg_wdata[5:0], 3))
		else $error("control bits not stored");
	high_clear_a: assert property (rd_s(HI) ##0 !ctrl_q[1]
		##0 !$past(ctrl_q[1]) |=> reg_rdata == 8'h00)
		else $error("high count not held clear");
	low_clear_a: assert property (rd_s(LO) ##0 !ctrl_q[0]
		##0 !$past(ctrl_q[0]) |=> reg_rdata == 8'h00)
		else $error("low count not held clear");
	high_hold_a: assert property (rd_s(HI) ##0 !ctrl_q[3]
		##0 ctrl_q[1] ##1 rd_s(HI) |=> reg_rdata == $past(reg_rdata))
		else $error("high count moved while disabled");
	low_hold_a: assert property (rd_s(LO) ##0 !ctrl_q[2]
		##0 ctrl_q[0] ##1 rd_s(LO) |=> reg_rdata == $past(reg_rdata))
		else $error("low count moved while disabled");
	// The output register takes the enable as written, so look ahead.
	irq_masked_a: assert property (clk_en && !ien_d |=> !irq)
		else $error("interrupt high while disabled");
	irq_cause_a: assert property ($rose(irq) |-> ien_q)
		else $error("interrupt rose while disabled");
	reset_quiet_a: assert property ($rose(resetn) |-> !irq
		&& reg_rdata == 8'h00) else $error("outputs not quiet after reset");
endmodule

bind aecp_top aecp_top_properties chk
(
	.mclk, .resetn, .clk_en, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .irq
);

// ==== aecp_event_src.sv ====
`timescale 1ns/1ps
// --------------------
// Outside event source driving the two event pins.
// --------------------
module aecp_event_src
(
	output wire logic high_event_pin,
	output wire logic low_event_pin
);
	logic [1:0] level = 2'b11; // Pins idle high between bursts.

	assign high_event_pin = level[1];
	assign low_event_pin  = level[0];

	// Each pulse is one falling and one rising edge. Widths sit off the
	// clock grid on purpose, yet stay long enough for a synchroniser.
	task automatic pulses(input bit hi, input int n);
		repeat (n)
		begin
			level[hi] = 1'b0;
			#43;
			level[hi] = 1'b1;
			#47;
		end
	endtask
endmodule

// ==== test_async_event_counter_pair.sv ====
`timescale 1ns/1ps
`define CHK(got, exp) \
	begin \
		compares++; \
		if ((got) !== (exp)) \
		begin \
			errors++; \
			$display("wrong value at %0t: %h not %h", $time, got, exp); \
		end \
	end
// --------------------
// Self-checking bench of the event counter pair.
// --------------------
module test_async_event_counter_pair;
	localparam logic [2:0] CS = aecp_pkg::OFS_CTRL_STATUS;
	localparam logic [2:0] HI = aecp_pkg::OFS_COUNT_HIGH;
	localparam logic [2:0] LO = aecp_pkg::OFS_COUNT_LOW;
	localparam logic [2:0] EG = aecp_pkg::OFS_EDGE_SEL;
	localparam logic [2:0] ST = aecp_pkg::OFS_IRQ_STATUS;
	localparam logic [2:0] MK = aecp_pkg::OFS_IRQ_MASK;
	localparam logic [2:0] CK = aecp_pkg::OFS_CLOCK_SEL;
	logic       mclk = 1'b0;
	logic       resetn = 1'b0;
	logic       clk_en = 1'b1; // Dropped once to check the freeze.
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic       irq;
	logic       high_event_pin;
	logic       low_event_pin;
	logic       external_gate_pin = 1'b1;
	logic       internal_gate_waveform = 1'b0;
	logic [7:0] val;           // Latest read result.
	logic [7:0] prev;          // Read result before it.
	int         errors = 0;
	int         compares = 0;

	aecp_top dut
	(
		.mclk, .resetn, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .irq, .high_event_pin, .low_event_pin,
		.external_gate_pin, .internal_gate_waveform
	);
	aecp_event_src src
	(
		.high_event_pin, .low_event_pin
	);

	// Free-running clock of 10 ns.
	always #5 mclk = ~mclk;

	// One write, then an idle cycle before the next request.
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask

	// Back-to-back reads; data are taken mid-cycle, where they stand.
	task automatic rd(input logic [2:0] a, input int n = 1);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		for (int i = 0; i < n; i++)
		begin
			@(posedge mclk);
			if (i == n - 1)
				reg_rd <= 1'b0;
			@(negedge mclk);
			prev = val;
			val  = reg_rdata;
		end
		@(posedge mclk);
	endtask

	// Read one place and compare it.
	task automatic see(input logic [2:0] a, input logic [7:0] e);
		rd(a);
		`CHK(val, e)
	endtask

	// Pulses on one pin, then time for the synchroniser to catch up.
	task automatic events(input bit hi, input int n);
		src.pulses(hi, n);
		repeat (8) @(posedge mclk);
	endtask

	// Print the counts and the verdict, then stop.
	task automatic summarize;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Every place reads zero after reset, the unused one included.
	task automatic t_reset;
		for (int a = 0; a < 8; a++)
			see(3'(a), 8'h00);
		$display("reset values done");
	endtask

	// Plain bits store; flags and counters refuse software writes.
	task automatic t_regs;
		wr(CS, 8'h1F);
		see(CS, 8'h1F);
		wr(CS, 8'hC0);
		see(CS, 8'h00);
		wr(HI, 8'hFF);
		see(HI, 8'h00);
		wr(LO, 8'hFF);
		see(LO, 8'h00);
		$display("register access done");
	endtask

	// Each edge code on both pins after a held clear.
	task automatic t_edges;
		int per [4] = '{1, 1, 2, 0};
		for (int c = 0; c < 4; c++)
		begin
			wr(EG, {4'h0, 2'(c), 2'(c)});
			wr(CS, 8'h1C);
			see(c[0] ? HI : LO, 8'h00);
			wr(CS, 8'h1F);
			events(1'b0, 2);
			events(1'b1, 3);
			see(LO, 8'(2 * per[c]));
			see(HI, 8'(3 * per[c]));
		end
		$display("edge select done");
	endtask

	// Count-up enables hold the halves; the chosen gate blocks counting.
	task automatic t_gate;
		wr(EG, 8'h00);
		wr(CS, 8'h1C);
		wr(CS, 8'h1F);
		events(1'b0, 1);
		events(1'b1, 1);
		wr(CS, 8'h13);
		events(1'b0, 2);
		events(1'b1, 2);
		rd(HI, 2);
		`CHK(val, 8'h01)
		rd(LO, 2);
		`CHK(val, 8'h01)
		external_gate_pin <= 1'b0;
		wr(CS, 8'h1F);
		events(1'b0, 2);
		see(LO, 8'h01);
		internal_gate_waveform <= 1'b1;
		wr(EG, 8'h10);
		events(1'b0, 2);
		see(LO, 8'h03);
		internal_gate_waveform <= 1'b0;
		external_gate_pin <= 1'b1;
		wr(EG, 8'h00);
		$display("enables and gate done");
	endtask

	// Wraps, flag clearing after a read, the interrupt and joined mode.
	task automatic t_ovf;
		wr(MK, 8'h01);
		wr(CS, 8'h1C);
		wr(CS, 8'h1F);
		events(1'b1, 256);
		see(HI, 8'h00);
		`CHK(irq, 1'b1)
		wr(CS, 8'h1F);
		see(CS, 8'h9F);
		wr(CS, 8'h1F);
		see(CS, 8'h1F);
		wr(MK, 8'h00);
		see(ST, 8'h01);
		`CHK(irq, 1'b0)
		wr(MK, 8'h01);
		see(ST, 8'h01);
		`CHK(irq, 1'b1)
		wr(ST, 8'h01);
		see(ST, 8'h00);
		`CHK(irq, 1'b0)
		events(1'b0, 256);
		see(CS, 8'h5F);
		wr(CS, 8'h0C);
		wr(CS, 8'h0F);
		events(1'b0, 256);
		see(LO, 8'h00);
		see(HI, 8'h01);
		see(CS, 8'h0F);
		$display("overflow done");
	endtask

	// Divided system clock sources over 16 cycles, then a frozen enable.
	// Reads 16 edges apart see an exact tick count whatever the phase.
	task automatic t_div;
		logic [7:0] x;
		for (int k = 1; k < 4; k++)
		begin
			wr(CK, {4'h0, 2'(k), 2'(k)});
			wr(CS, 8'h1F);
			rd(LO);
			x = val;
			repeat (14) @(posedge mclk);
			rd(LO);
			`CHK(8'(val - x), 8'(16 >> k))
			rd(HI);
			x = val;
			repeat (14) @(posedge mclk);
			rd(HI);
			`CHK(8'(val - x), 8'(16 >> k))
		end
		wr(CK, 8'h05);
		rd(LO);
		x = val;
		clk_en <= 1'b0;
		repeat (16) @(posedge mclk);
		clk_en <= 1'b1;
		rd(LO);
		`CHK(8'(val - x), 8'h01)
		$display("divided clocks done");
	endtask

	// Main sequence after five cycles of reset.
	initial
	begin
		repeat (5) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		t_reset();
		t_regs();
		t_edges();
		t_gate();
		t_ovf();
		t_div();
		summarize();
	end

	// A hang counts as a mismatch and ends the run.
	initial
	begin
		#500000;
		errors++;
		summarize();
	end
endmodule
